// ### dv/rbs_pin_model.sv
/*
 * far side of the external reset pin: pull-up, the block's open-drain pull
 * and a push-button.
 * assumes the bench drives press synchronously to its own clock.
 */
`timescale 1ns/100ps
`default_nettype none
module rbs_pin_model (
	input  wire logic pin_out, // level the block drives
	input  wire logic pin_oe,  // high while the block drives
	input  wire logic press,   // push-button held down
	output logic      pin_in   // resolved wire level
);
	// pull-up wins unless someone pulls low; never shows a stale value
	always_comb begin
		pin_in = ((pin_oe && !pin_out) || press) ? 1'b0 : 1'b1;
	end
endmodule // rbs_pin_model
`default_nettype wire

// ### dv/tb_top.sv
/*
 * self-checking bench for the reset and boot selection block.
 * assumes the design's own assertions run alongside; pulse shortened to 8.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import rbs_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int PULSE = 8; // short pulse keeps the run brief
	logic clk, rst, bo_low, bo_dis, bo_en, sw_req, wd_req, wk_req, press;
	logic set_c, clr_c, idx, erase, tst, pa0, pa1, m_en, m_sm, m_we, to_gpio;
	logic [3:0] m_thr_in;
	wire logic pin_in, pin_out, pin_oe, core_rst, flash, fpp, bo_on;
	wire logic m_on, m_smp, sysfn;
	wire logic [1:0] opt;
	wire logic [31:0] baddr;
	wire logic [3:0] m_thr;
	wire rbs_cause_t cause;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	rbs_reset_boot #(.PULSE_CYC(PULSE)) dut (.clk(clk), .rst(rst),
		.brownout_low(bo_low), .brownout_disable_set(bo_dis),
		.brownout_enable_set(bo_en), .software_reset_req(sw_req),
		.watchdog_reset_req(wd_req), .wakeup_reset_req(wk_req),
		.external_reset_pin_in(pin_in), .external_reset_pin_out(pin_out),
		.external_reset_pin_oe(pin_oe), .core_reset(core_rst),
		.reset_cause(cause), .opt_set_cmd(set_c), .opt_clear_cmd(clr_c),
		.opt_index(idx), .erase_pin(erase), .nonvolatile_option_bits(opt),
		.boot_from_flash(flash), .boot_address(baddr),
		.test_select_pin(tst), .port_a_line_zero(pa0),
		.port_a_line_one(pa1), .fast_programming_port(fpp),
		.brownout_enabled(bo_on), .monitor_enable_set(m_en),
		.monitor_sample_set(m_sm), .monitor_threshold_in(m_thr_in),
		.monitor_config_we(m_we), .monitor_enabled(m_on),
		.monitor_sampled(m_smp), .monitor_threshold(m_thr),
		.pins_to_gpio(to_gpio), .pins_system_function(sysfn));
	rbs_pin_model partner (.pin_out(pin_out), .pin_oe(pin_oe),
		.press(press), .pin_in(pin_in));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			results();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset();
		rst <= 1;
		repeat (19) @(posedge clk);
		#1;
		chk("core reset in rst", 32'h1, 32'(core_rst));
		@(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1;
		chk("cause", 32'(RBS_CAUSE_GENERAL), 32'(cause));
		chk("option bits", 32'h0, 32'(opt));
		chk("boot flash", 32'h0, 32'(flash));
		chk("boot address", 32'h0, baddr);
		chk("brownout on", 32'h1, 32'(bo_on));
		chk("monitor", 32'h0, {26'h0, m_on, m_smp, m_thr});
		chk("system pins", 32'h1, 32'(sysfn));
		chk("pin drive", 32'h0, 32'(pin_oe));
		chk("pin level", 32'h0, 32'(pin_out));
		chk("pin released", 32'h1, 32'(pin_in));
	endtask
	task automatic opt_cmd(input logic s, c, i, e, input logic [1:0] exp);
		@(posedge clk);
		set_c <= s; clr_c <= c; idx <= i; erase <= e;
		@(posedge clk);
		set_c <= 0; clr_c <= 0; erase <= 0;
		#1;
		chk("option bits", 32'(exp), 32'(opt));
		chk("boot flash", 32'(exp[1]), 32'(flash));
	endtask
	// counts pulse edges; a watchdog request mid-pulse must be ignored
	task automatic hold_pulse(input int len, input rbs_cause_t exp);
		n = 0;
		while (pin_oe === 1'b1 && n < 100) begin
			@(posedge clk);
			wd_req <= (n == 1);
			#1;
			n++;
		end
		chk("pulse length", 32'(len), 32'(n));
		chk("cause held", 32'(exp), 32'(cause));
		@(posedge clk);
		#1;
		chk("core reset off", 32'h0, 32'(core_rst));
	endtask
	task automatic fire(input logic w, s, k, input rbs_cause_t exp);
		@(posedge clk);
		wd_req <= w; sw_req <= s; wk_req <= k;
		@(posedge clk);
		wd_req <= 0; sw_req <= 0; wk_req <= 0;
		#1;
		chk("cause", 32'(exp), 32'(cause));
		chk("core reset", 32'h1, 32'(core_rst));
		hold_pulse(PULSE, exp);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{bo_low, bo_dis, bo_en, sw_req, wd_req, wk_req, press} = '0;
		{set_c, clr_c, idx, erase, m_en, m_sm, m_we, to_gpio} = '0;
		{tst, pa0, pa1} = 3'h7;
		m_thr_in = 4'h0;
		rst = 1;
		do_reset();
		opt_cmd(1, 0, 1, 0, 2'h2);
		opt_cmd(1, 0, 0, 0, 2'h3);
		opt_cmd(0, 1, 0, 0, 2'h2);
		opt_cmd(1, 0, 1, 1, 2'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{tst, pa0, pa1} <= 3'(i);
			#1;
			chk("fast port", 32'(i == 0), 32'(fpp));
		end
		@(posedge clk);
		bo_low <= 1;
		#1;
		chk("brownout reset", 32'h1, 32'(core_rst));
		@(posedge clk);
		bo_dis <= 1; bo_en <= 1;
		@(posedge clk);
		bo_dis <= 0; bo_en <= 0;
		#1;
		chk("brownout off", 32'h0, 32'({bo_on, core_rst}));
		@(posedge clk);
		bo_en <= 1;
		@(posedge clk);
		bo_en <= 0;
		#1;
		chk("brownout back", 32'h3, 32'({bo_on, core_rst}));
		@(posedge clk);
		bo_low <= 0;
		m_en <= 1; m_sm <= 1; m_thr_in <= 4'hf; m_we <= 1; to_gpio <= 1;
		@(posedge clk);
		m_we <= 0; to_gpio <= 0;
		#1;
		chk("monitor", 32'h3f, 32'({m_on, m_smp, m_thr}));
		chk("system pins", 32'h0, 32'(sysfn));
		fire(1, 1, 0, RBS_CAUSE_WATCHDOG);
		fire(0, 1, 1, RBS_CAUSE_SOFTWARE);
		fire(0, 0, 1, RBS_CAUSE_WAKEUP);
		chk("monitor kept", 32'h3f, 32'({m_on, m_smp, m_thr}));
		@(posedge clk);
		press <= 1;
		@(posedge clk);
		@(posedge clk);
		press <= 0;
		#1;
		chk("cause", 32'(RBS_CAUSE_USER), 32'(cause));
		hold_pulse(PULSE - 1, RBS_CAUSE_USER);
		do_reset();
		results();
	end
endmodule // tb_top
`default_nettype wire

// ### rtl/rbs_cfg.svh
/*
 * constants for the reset and boot selection block: boot address, pulse
 * lengths, option bit positions and reset values.
 * assumes a single 50 MHz system clock and one include per compile unit.
 */
//
// Behaviour
// - fetch always starts at address zero
// - option bit one set maps flash, clear rom
// - unprogrammed option bit boots from rom
// - erase pin clears option bit one
// - two option bits, set and clear commands
// - test pin and port lines low enter programming
// - record last reset cause for software
// - drive shaped reset pin, button gives user reset
// - power-on undervoltage resets whole chip
// - core brownout asserts core reset
// - brownout enabled at reset, software may disable
// - supply monitor off at reset, 16 thresholds
// - configuration kept across core resets
// - supply logic on slow clock, own reset; here it runs on clk and is reset by rst
// - shared pins reset to system function
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH

// ------------------------------------------------------------
// boot addressing
// ------------------------------------------------------------
`define RBS_BOOT_ADDR      32'h0000_0000
`define RBS_OPT_SECURITY   0
`define RBS_OPT_BOOT       1
`define RBS_OPT_RESET      2'h0

// ------------------------------------------------------------
// reset shaping, in microseconds and derived cycles at 50 MHz
// ------------------------------------------------------------
`define RBS_CLK_MHZ        50
`define RBS_PIN_PULSE_US   60
`define RBS_PIN_PULSE_CYC  (`RBS_PIN_PULSE_US * `RBS_CLK_MHZ)
`define RBS_CNT_W          12

// ------------------------------------------------------------
// supply monitor
// ------------------------------------------------------------
`define RBS_THR_W          4
`define RBS_THR_RESET      4'h0

`endif

// ### rtl/rbs_pkg.sv
/*
 * types for the reset and boot selection block.
 * assumes nothing beyond a SystemVerilog compile.
 */
package rbs_pkg;
	// cause of the most recent reset
	typedef enum logic [2:0] {
		RBS_CAUSE_GENERAL  = 3'h0,
		RBS_CAUSE_WAKEUP   = 3'h1,
		RBS_CAUSE_WATCHDOG = 3'h2,
		RBS_CAUSE_SOFTWARE = 3'h3,
		RBS_CAUSE_USER     = 3'h4
	} rbs_cause_t;
	// reset sequencer states
	typedef enum logic [1:0] {
		RBS_IDLE,
		RBS_PULSE,
		RBS_RELEASE
	} rbs_state_t;
endpackage : rbs_pkg

// ### rtl/rbs_reset_boot.sv
/*
 * reset and boot selection: gathers reset requests, stretches them into a
 * shaped reset pulse on the external reset pin, records the cause, holds
 * the option bits and picks the boot memory, and decodes the programming
 * strap.
 * assumes all inputs are synchronous to clk; rst is the power-on reset
 * from the io supply monitor, asynchronous and active high. the supply
 * monitor settings are held in registers here, clocked by clk and reset by
 * rst, in place of the slow-clock domain of the supply controller.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rbs_cfg.svh"

module rbs_reset_boot #(
	parameter int PULSE_CYC = `RBS_PIN_PULSE_CYC // shaped pulse length
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               brownout_low,
	input  wire logic               brownout_disable_set,
	input  wire logic               brownout_enable_set,
	input  wire logic               software_reset_req,
	input  wire logic               watchdog_reset_req,
	input  wire logic               wakeup_reset_req,
	input  wire logic               external_reset_pin_in,
	output logic                    external_reset_pin_out,
	output logic                    external_reset_pin_oe,
	output logic                    core_reset,
	output rbs_pkg::rbs_cause_t     reset_cause,
	input  wire logic               opt_set_cmd,
	input  wire logic               opt_clear_cmd,
	input  wire logic               opt_index,
	input  wire logic               erase_pin,
	output logic [1:0]              nonvolatile_option_bits,
	output logic                    boot_from_flash,
	output logic [31:0]             boot_address,
	input  wire logic               test_select_pin,
	input  wire logic               port_a_line_zero,
	input  wire logic               port_a_line_one,
	output logic                    fast_programming_port,
	output logic                    brownout_enabled,
	input  wire logic               monitor_enable_set,
	input  wire logic               monitor_sample_set,
	input  wire logic [3:0]         monitor_threshold_in,
	input  wire logic               monitor_config_we,
	output logic                    monitor_enabled,
	output logic                    monitor_sampled,
	output logic [3:0]              monitor_threshold,
	input  wire logic               pins_to_gpio,
	output logic                    pins_system_function
);
	import rbs_pkg::*;

	// ------------------------------------------------------------
	// reset sequencer state
	// ------------------------------------------------------------
	rbs_state_t             state;      // sequencer state
	rbs_state_t             next_state;
	logic [`RBS_CNT_W-1:0]  cnt;        // pulse length counter
	logic [`RBS_CNT_W-1:0]  next_cnt;
	rbs_cause_t             next_cause;
	logic                   req_any;    // any internal request

	// pin sampled low while not driven by us means a push-button
	logic user_req;
	assign user_req = !external_reset_pin_in && !external_reset_pin_oe;
	assign req_any  = software_reset_req || watchdog_reset_req ||
	                  wakeup_reset_req;

	// next state; requests during a pulse are ignored so the first cause
	// recorded is the one that started the pulse
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_cause = reset_cause;
		case (state)
			RBS_IDLE: begin
				if (req_any || user_req) begin
					next_state = RBS_PULSE;
					next_cnt   = '0;
					// priority: watchdog, software, wakeup, user
					if (watchdog_reset_req)
						next_cause = RBS_CAUSE_WATCHDOG;
					else if (software_reset_req)
						next_cause = RBS_CAUSE_SOFTWARE;
					else if (wakeup_reset_req)
						next_cause = RBS_CAUSE_WAKEUP;
					else
						next_cause = RBS_CAUSE_USER;
				end
			end
			RBS_PULSE: begin
				// stretch to a fixed length for external devices
				if (cnt == PULSE_CYC[`RBS_CNT_W-1:0] - 1'b1)
					next_state = RBS_RELEASE;
				else
					next_cnt = cnt + 1'b1;
			end
			RBS_RELEASE: begin
				// wait for the pin to rise so our own pulse is not seen
				// as a button press
				if (external_reset_pin_in)
					next_state = RBS_IDLE;
			end
			default: next_state = RBS_IDLE;
		endcase
	end

	// cause register is kept until a new event overwrites it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state       <= RBS_IDLE;
			cnt         <= '0;
			reset_cause <= RBS_CAUSE_GENERAL;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			reset_cause <= next_cause;
		end
	end

	// drive the pin low only during the shaped pulse; release is open drain
	assign external_reset_pin_out = 1'b0;
	assign external_reset_pin_oe  = (state == RBS_PULSE);

	// ------------------------------------------------------------
	// pulse length watch, read only by the checks below
	// ------------------------------------------------------------
	// measuring the pin drive apart from cnt keeps a counter fault from
	// hiding behind the sequencer's own arithmetic
	localparam logic [`RBS_CNT_W-1:0] PULSE_LEN = PULSE_CYC[`RBS_CNT_W-1:0];
	logic [`RBS_CNT_W-1:0]  oe_run;      // cycles the pin has been driven
	logic [`RBS_CNT_W-1:0]  next_oe_run;
	// saturate rather than wrap, so a stuck drive stays visible
	always_comb begin
		if (!external_reset_pin_oe)
			next_oe_run = '0;
		else if (&oe_run)
			next_oe_run = oe_run;
		else
			next_oe_run = oe_run + 1'b1;
	end
	// register the run length
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			oe_run <= '0;
		else
			oe_run <= next_oe_run;
	end

	// ------------------------------------------------------------
	// brownout and core reset
	// ------------------------------------------------------------
	logic next_bod_en;
	always_comb begin
		next_bod_en = brownout_enabled;
		if (brownout_disable_set)
			next_bod_en = 1'b0;
		else if (brownout_enable_set)
			next_bod_en = 1'b1;
	end
	// the power-on reset sets this, the core reset does not
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			brownout_enabled <= 1'b1;
		else
			brownout_enabled <= next_bod_en;
	end

	// core reset: power-on, brownout, or the shaped pulse and its release wait; a disabled detector
	// is a software choice meant for sleep modes
	assign core_reset = rst || (brownout_low && brownout_enabled) ||
	                    (state != RBS_IDLE);

	// ------------------------------------------------------------
	// option bits and boot mapping
	// ------------------------------------------------------------
	logic [1:0] next_opt;
	always_comb begin
		next_opt = nonvolatile_option_bits;
		if (opt_set_cmd)
			next_opt[opt_index] = 1'b1;
		else if (opt_clear_cmd)
			next_opt[opt_index] = 1'b0;
		// erase wins over a set arriving together
		if (erase_pin)
			next_opt[`RBS_OPT_BOOT] = 1'b0;
	end
	// models the non-volatile cell: only the power-on reset loads the
	// unprogrammed value, core resets leave it alone
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			nonvolatile_option_bits <= `RBS_OPT_RESET;
		else
			nonvolatile_option_bits <= next_opt;
	end

	assign boot_from_flash = nonvolatile_option_bits[`RBS_OPT_BOOT];
	assign boot_address    = `RBS_BOOT_ADDR;

	// ------------------------------------------------------------
	// programming strap
	// ------------------------------------------------------------
	assign fast_programming_port = !test_select_pin &&
	                               !port_a_line_zero && !port_a_line_one;

	// ------------------------------------------------------------
	// supply monitor settings and shared pin function
	// ------------------------------------------------------------
	logic       next_mon_en;
	logic       next_mon_smp;
	logic [3:0] next_mon_thr;
	logic       next_pin_sys;
	always_comb begin
		next_mon_en  = monitor_enabled;
		next_mon_smp = monitor_sampled;
		next_mon_thr = monitor_threshold;
		next_pin_sys = pins_system_function;
		if (monitor_config_we) begin
			next_mon_en  = monitor_enable_set;
			next_mon_smp = monitor_sample_set;
			next_mon_thr = monitor_threshold_in;
		end
		if (pins_to_gpio)
			next_pin_sys = 1'b0;
	end
	// supply controller owns its reset, tied here to the power-on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			monitor_enabled      <= 1'b0;
			monitor_sampled      <= 1'b0;
			monitor_threshold    <= `RBS_THR_RESET;
			pins_system_function <= 1'b1;
		end else begin
			monitor_enabled      <= next_mon_en;
			monitor_sampled      <= next_mon_smp;
			monitor_threshold    <= next_mon_thr;
			pins_system_function <= next_pin_sys;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// all checks are gated by the power-on reset; the pulse length ones
	// lean on oe_run, so they also catch a pulse cut short or stretched
	a_pulse_drives_pin: assert property (@(posedge clk) disable iff (rst)
		(state == RBS_IDLE && software_reset_req) |=>
		external_reset_pin_oe [*8])
		else $error("reset pin not driven after request");
	a_pulse_length: assert property (@(posedge clk) disable iff (rst)
		$fell(external_reset_pin_oe) |-> oe_run == PULSE_LEN)
		else $error("reset pulse length wrong");
	a_pulse_bounded: assert property (@(posedge clk) disable iff (rst)
		oe_run <= PULSE_LEN)
		else $error("reset pulse too long");
	a_release_idle: assert property (@(posedge clk) disable iff (rst)
		(state == RBS_RELEASE && external_reset_pin_in) |=>
		state == RBS_IDLE)
		else $error("sequencer stuck after release");
	a_user_cause: assert property (@(posedge clk) disable iff (rst)
		(state == RBS_IDLE && user_req && !req_any) |=>
		reset_cause == RBS_CAUSE_USER)
		else $error("user reset cause not recorded");
	a_wdt_cause: assert property (@(posedge clk) disable iff (rst)
		(state == RBS_IDLE && watchdog_reset_req) |=>
		reset_cause == RBS_CAUSE_WATCHDOG)
		else $error("watchdog cause not recorded");
	a_cause_stable: assert property (@(posedge clk) disable iff (rst)
		(state != RBS_IDLE) |=> $stable(reset_cause))
		else $error("cause changed during pulse");
	a_erase_clears: assert property (@(posedge clk) disable iff (rst)
		erase_pin |=> !boot_from_flash)
		else $error("erase did not select rom");
	a_set_flash: assert property (@(posedge clk) disable iff (rst)
		(opt_set_cmd && opt_index && !erase_pin) |=> boot_from_flash)
		else $error("set command did not select flash");
	a_opt_clear: assert property (@(posedge clk) disable iff (rst)
		(opt_clear_cmd && !opt_set_cmd && !opt_index) |=>
		!nonvolatile_option_bits[`RBS_OPT_SECURITY])
		else $error("clear command did not clear bit");
	a_bod_reset: assert property (@(posedge clk) disable iff (rst)
		(brownout_low && brownout_enabled) |-> core_reset)
		else $error("brownout did not reset core");
	a_bod_disable: assert property (@(posedge clk) disable iff (rst)
		brownout_disable_set |=> !brownout_enabled)
		else $error("brownout not disabled");
	a_mon_load: assert property (@(posedge clk) disable iff (rst)
		monitor_config_we |=>
		monitor_threshold == $past(monitor_threshold_in))
		else $error("monitor threshold not loaded");
	a_strap_enter: assert property (@(posedge clk) disable iff (rst)
		(!test_select_pin && !port_a_line_zero && !port_a_line_one) |->
		fast_programming_port)
		else $error("programming strap not decoded");
	a_pins_gpio: assert property (@(posedge clk) disable iff (rst)
		pins_to_gpio |=> !pins_system_function)
		else $error("pins did not switch to gpio");

	// main scenarios the bench is expected to reach
	c_user_reset: cover property (@(posedge clk) disable iff (rst)
		state == RBS_IDLE && user_req ##1 state == RBS_PULSE);
	c_pulse_done: cover property (@(posedge clk) disable iff (rst)
		state == RBS_PULSE ##1 state == RBS_RELEASE);
	c_boot_flash: cover property (@(posedge clk) disable iff (rst)
		boot_from_flash ##1 erase_pin ##1 !boot_from_flash);
	c_wdt_reset: cover property (@(posedge clk) disable iff (rst)
		state == RBS_IDLE && watchdog_reset_req ##1
		reset_cause == RBS_CAUSE_WATCHDOG);
	c_strap_entry: cover property (@(posedge clk) disable iff (rst)
		fast_programming_port);

endmodule // rbs_reset_boot

`default_nettype wire
